//--- rtl/psu_pmbus_command_handler.sv
// Purpose: bus command handler for reports and settings of the supply
// Assumes: a byte engine on pclk delivers frame events and bytes
// Notes: registers on apb; all outputs registered
`timescale 1ns/1ps
`default_nettype none
`include "psu_params.svh"
module psu_pmbus_command_handler #(
  parameter int CH = 2,
  parameter int PW = 4,
  parameter logic [6:0] SLAVE_ADDR = `SLAVE_ADDR_DEF
) (
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // byte engine side
  input wire logic frm_start,
  input wire logic frm_stop,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic tx_next,
  output logic [7:0] tx_data,
  // plant side
  input wire logic [15:0] pot_level,
  input wire logic [7:0] fault_set,
  output logic [15:0] vout_setpoint,
  output logic [15:0] opp_limit,
  output logic [15:0] fan1_duty,
  output logic [15:0] fan2_duty,
  output logic [7:0] faults,
  output logic fault_clear
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    psu_pkg::frame_st_t st;
    logic [7:0] crc;
    logic [2:0] cnt;
    logic [7:0] cmd;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [1:0] rd_idx;
    logic [7:0] tx;
    logic [PW-1:0] page;
    logic opp_en;
    logic [CH-1:0] remote;
    logic [CH-1:0][15:0] maxi;
    logic [CH-1:0][15:0] mini;
    logic [CH-1:0][15:0] fan;
    logic [15:0] vref;
    logic [15:0] over_power_protection;
    logic [15:0] fan1;
    logic [15:0] fan2;
    logic [15:0] setp;
    logic [7:0] faults;
    logic clr_pulse;
    logic pec_err;
    logic clr_seen;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t s_q, s_d;
  logic [7:0] crc_byte;
  logic [7:0] crc_next;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // selected page, out of range falls back to page 0
  function automatic int unsigned chan(input logic [PW-1:0] p);
    chan = (int'(p) < CH) ? int'(p) : 0;
  endfunction : chan

  // mapped register offsets
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == `OFS_CTRL) || (a == `OFS_REMOTE) ||
             (a == `OFS_MAX_I) || (a == `OFS_MIN_I) ||
             (a == `OFS_FAN_DUTY) || (a == `OFS_VREF) ||
             (a == `OFS_OPP) || (a == `OFS_FAN_OVR) ||
             (a == `OFS_STATUS);
  endfunction : mapped

  // reply length in data bytes for a read command
  function automatic logic [1:0] rd_len(input logic [7:0] c);
    if (c == `CMD_REMOTE_STAT) begin
      rd_len = 2'd1;
    end else if ((c == `CMD_MAX_CURRENT) || (c == `CMD_MIN_CURRENT) ||
                 (c == `CMD_FAN_DUTY)) begin
      rd_len = 2'd2;
    end else begin
      rd_len = 2'd0;
    end
  endfunction : rd_len

  // shared crc step: transmitted byte while reading, else received
  assign crc_byte = (s_q.st == psu_pkg::ST_RD) ? s_q.tx : rx_data;

  pec_crc8 u_crc (
    .crc_in(s_q.crc),
    .data_in(crc_byte),
    .crc_out(crc_next)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    int unsigned c;
    logic [15:0] val;
    logic [15:0] wv;
    logic [1:0] len;
    logic [7:0] clr;
    logic acc;
    logic pec_set;
    s_d = s_q;
    acc = 1'b0;
    val = 16'h0000;
    pec_set = 1'b0;
    c = chan(s_q.page);
    clr = 8'h00;
    len = rd_len(s_q.cmd);
    wv = {s_q.d1, s_q.d0}; // [R2]
    s_d.clr_pulse = 1'b0;
    // reply word for the selected channel
    if (s_q.cmd == `CMD_MAX_CURRENT) begin
      val = s_q.maxi[c]; // [R1] [R4]
    end else if (s_q.cmd == `CMD_MIN_CURRENT) begin
      val = s_q.mini[c]; // [R3] [R4]
    end else if (s_q.cmd == `CMD_FAN_DUTY) begin
      val = s_q.fan[c]; // [R8] [R4]
    end else if (s_q.cmd == `CMD_REMOTE_STAT) begin
      val = {15'h0000, s_q.remote[c]}; // [R5] [R7]
    end else begin
      val = 16'h0000;
    end

    // frame parser
    if (frm_start) begin
      s_d.st = psu_pkg::ST_ADDR;
      if (s_q.st != psu_pkg::ST_WR) begin
        s_d.crc = `CRC_INIT; // [R18]
      end
    end else begin
      case (s_q.st)
        psu_pkg::ST_IDLE: begin
        end
        psu_pkg::ST_ADDR: begin
          if (rx_valid) begin
            if (rx_data[7:1] != SLAVE_ADDR) begin
              s_d.st = psu_pkg::ST_SKIP;
            end else if (!rx_data[0]) begin
              // write phase, crc carries on over the address byte
              s_d.st = psu_pkg::ST_WR;
              s_d.crc = crc_next; // [R18]
              s_d.cnt = 3'd1;
            end else if (s_q.cnt == 3'd2) begin
              // read after command and repeated start
              s_d.st = psu_pkg::ST_RD; // [R19]
              s_d.crc = crc_next; // [R18]
              s_d.rd_idx = 2'd0;
              s_d.tx = (len == 2'd0) ? crc_next : val[7:0];
            end else begin
              s_d.st = psu_pkg::ST_SKIP;
            end
          end
        end
        psu_pkg::ST_WR: begin
          if (rx_valid) begin
            s_d.crc = crc_next; // [R18]
            if (s_q.cnt != 3'd7) begin
              s_d.cnt = s_q.cnt + 3'd1;
            end
            if (s_q.cnt == 3'd1) begin
              s_d.cmd = rx_data;
            end else if (s_q.cnt == 3'd2) begin
              s_d.d0 = rx_data;
            end else if (s_q.cnt == 3'd3) begin
              s_d.d1 = rx_data;
            end
          end else if (frm_stop) begin
            s_d.st = psu_pkg::ST_IDLE;
            s_d.cnt = 3'd0;
            if (s_q.cnt >= `CLEAR_FRAME_LEN && s_q.crc != 8'h00) begin
              s_d.pec_err = 1'b1; // [R20]
              pec_set = 1'b1;
            end else if (s_q.crc == 8'h00) begin
              // checked frame, apply now and only now
              if (s_q.cmd == `CMD_CLEAR_FAULTS &&
                  s_q.cnt == `CLEAR_FRAME_LEN) begin // [R10] [R21]
                clr = 8'hff; // [R9]
                s_d.clr_pulse = 1'b1;
                s_d.clr_seen = 1'b1;
              end else if (s_q.cnt == `SET_FRAME_LEN) begin // [R21]
                if (s_q.cmd == `CMD_SET_VREF) begin
                  s_d.vref = wv; // [R11]
                end else if (s_q.cmd == `CMD_OPP_LIMIT) begin
                  if (s_q.opp_en) begin
                    s_d.over_power_protection = wv; // [R13] [R14]
                  end
                end else if (s_q.cmd == `CMD_FAN1_DUTY ||
                             s_q.cmd == `CMD_FAN2_DUTY) begin
                  acc = (wv == 16'h0000) || // [R16]
                        (wv > s_q.fan[c] && wv <= `FAN_DUTY_MAX);
                  if (acc && s_q.cmd == `CMD_FAN1_DUTY) begin
                    s_d.fan1 = wv; // [R15]
                  end else if (acc) begin
                    s_d.fan2 = wv; // [R17]
                  end
                end
              end
            end
          end
        end
        psu_pkg::ST_RD: begin
          if (frm_stop) begin
            s_d.st = psu_pkg::ST_IDLE;
            s_d.cnt = 3'd0;
          end else if (tx_next && s_q.rd_idx < len) begin
            // data byte out, pec follows the last one
            s_d.crc = crc_next; // [R18]
            s_d.rd_idx = s_q.rd_idx + 2'd1;
            s_d.tx = (s_q.rd_idx + 2'd1 < len) ? val[15:8] : crc_next; // [R2]
          end
        end
        psu_pkg::ST_SKIP: begin
          if (frm_stop) begin
            s_d.st = psu_pkg::ST_IDLE;
            s_d.cnt = 3'd0;
          end
        end
        default: begin
          s_d.st = psu_pkg::ST_IDLE;
        end
      endcase
    end

    // latched faults, a new fault wins over the clear
    s_d.faults = (s_q.faults & ~clr) | fault_set; // [R9]

    // setpoint source by control mode of the selected page
    s_d.setp = s_q.remote[c] ? s_q.vref : pot_level; // [R6]

    // apb access: data in first cycle, effect at the ready edge
    s_d.pslverr = 1'b0;
    s_d.pready = psel && penable && !s_q.pready;
    if (psel && penable && !s_q.pready) begin
      s_d.pslverr = !mapped(paddr);
      s_d.prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (paddr == `OFS_CTRL) begin
          s_d.prdata[PW-1:0] = s_q.page;
          s_d.prdata[`CTRL_OPP_EN_BIT] = s_q.opp_en;
        end else if (paddr == `OFS_REMOTE) begin
          s_d.prdata[CH-1:0] = s_q.remote;
        end else if (paddr == `OFS_MAX_I) begin
          s_d.prdata[15:0] = s_q.maxi[c];
        end else if (paddr == `OFS_MIN_I) begin
          s_d.prdata[15:0] = s_q.mini[c];
        end else if (paddr == `OFS_FAN_DUTY) begin
          s_d.prdata[15:0] = s_q.fan[c];
        end else if (paddr == `OFS_VREF) begin
          s_d.prdata[15:0] = s_q.vref;
        end else if (paddr == `OFS_OPP) begin
          s_d.prdata[15:0] = s_q.over_power_protection;
        end else if (paddr == `OFS_FAN_OVR) begin
          s_d.prdata = {s_q.fan2, s_q.fan1};
        end else if (paddr == `OFS_STATUS) begin
          s_d.prdata[`STAT_PEC_ERR_BIT] = s_q.pec_err;
          s_d.prdata[`STAT_CLR_SEEN_BIT] = s_q.clr_seen;
          s_d.prdata[15:8] = s_q.faults;
        end
      end
    end
    if (psel && penable && s_q.pready && pwrite) begin
      if (paddr == `OFS_CTRL) begin
        s_d.page = pwdata[PW-1:0];
        s_d.opp_en = pwdata[`CTRL_OPP_EN_BIT];
      end else if (paddr == `OFS_REMOTE) begin
        s_d.remote = pwdata[CH-1:0];
      end else if (paddr == `OFS_MAX_I) begin
        s_d.maxi[c] = pwdata[15:0];
      end else if (paddr == `OFS_MIN_I) begin
        s_d.mini[c] = pwdata[15:0];
      end else if (paddr == `OFS_FAN_DUTY) begin
        s_d.fan[c] = pwdata[15:0];
      end else if (paddr == `OFS_STATUS) begin
        // write one to clear, the frame path sets first
        if (pwdata[`STAT_PEC_ERR_BIT] && !pec_set) begin
          s_d.pec_err = 1'b0;
        end
        if (pwdata[`STAT_CLR_SEEN_BIT] && !s_d.clr_pulse) begin
          s_d.clr_seen = 1'b0;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.st <= psu_pkg::ST_IDLE;
      s_q.vref <= `RST_VREF;
      s_q.over_power_protection <= `RST_OPP_LIMIT;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state register
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign tx_data = s_q.tx;
  assign vout_setpoint = s_q.setp;
  assign opp_limit = s_q.over_power_protection;
  assign fan1_duty = s_q.fan1;
  assign fan2_duty = s_q.fan2;
  assign faults = s_q.faults;
  assign fault_clear = s_q.clr_pulse;
endmodule : psu_pmbus_command_handler
`default_nettype wire

//--- common/psu_params.svh
// Purpose: constants of the power supply bus command handler
// Assumes: included by bare name; definitions only
// Notes: offsets are byte addresses on the register bus
// Notes on behaviour
// [R1] command cc returns max current, 0.1 A
// [R2] current words sent low byte first
// [R3] command cd returns min current, 0.1 A
// [R4] readings follow the selected channel only
// [R5] command ce returns 0 local, 1 remote
// [R6] local follows potentiometer, remote follows bus
// [R7] remote status reports the selected page
// [R8] command e1 returns fan duty 0 to 1000
// [R9] command 03 clears all latched faults
// [R10] fault clear frame carries no data
// [R11] command 21 sets voltage reference, 0.1 V
// [R12] host keeps reference within ten percent
// [R13] command 68 sets over power limit
// [R14] limit applies only while protection enabled
// [R15] command 3b sets fan 1 duty
// [R16] override only above present duty; zero cancels
// [R17] command 3c sets fan 2 duty
// [R18] crc8 poly 07, init zero, all bytes
// [R19] read: addr w, cmd, restart, addr r, data, pec
// [R20] bad pec write frame is discarded
// [R21] settings applied only after checked pec
`ifndef PSU_PARAMS_SVH
`define PSU_PARAMS_SVH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_SET_VREF 8'h21
`define CMD_FAN1_DUTY 8'h3b
`define CMD_FAN2_DUTY 8'h3c
`define CMD_OPP_LIMIT 8'h68
`define CMD_MAX_CURRENT 8'hcc
`define CMD_MIN_CURRENT 8'hcd
`define CMD_REMOTE_STAT 8'hce
`define CMD_FAN_DUTY 8'he1

// ----------------------------------------------------------------
// frame constants
// ----------------------------------------------------------------
`define CRC_POLY 8'h07
`define CRC_INIT 8'h00
`define SLAVE_ADDR_DEF 7'h10
`define CLEAR_FRAME_LEN 3'd3
`define SET_FRAME_LEN 3'd5
`define FAN_DUTY_MAX 16'h03e8

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_REMOTE 8'h04
`define OFS_MAX_I 8'h08
`define OFS_MIN_I 8'h0c
`define OFS_FAN_DUTY 8'h10
`define OFS_VREF 8'h14
`define OFS_OPP 8'h18
`define OFS_FAN_OVR 8'h1c
`define OFS_STATUS 8'h20

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CTRL_OPP_EN_BIT 8
`define STAT_PEC_ERR_BIT 0
`define STAT_CLR_SEEN_BIT 1
`define RST_OPP_LIMIT 16'h35e8
`define RST_VREF 16'h00f0

`endif

//--- common/psu_pkg.sv
// Purpose: shared types of the command handler
// Assumes: nothing
// Notes: frame parser states
`default_nettype none
package psu_pkg;
  // ----------------------------------------------------------------
  // frame parser states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WR,
    ST_RD,
    ST_SKIP
  } frame_st_t;
endpackage : psu_pkg
`default_nettype wire

//--- rtl/pec_crc8.sv
// Purpose: one byte step of the packet error code
// Assumes: msb first, no reflection
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "psu_params.svh"
module pec_crc8 (
  // running code and new byte
  input wire logic [7:0] crc_in,
  input wire logic [7:0] data_in,
  // updated code
  output logic [7:0] crc_out
);
  // shift the byte through the divisor
  always_comb begin
    logic [7:0] c;
    c = crc_in ^ data_in;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0}; // [R18]
    end
    crc_out = c;
  end
endmodule : pec_crc8
`default_nettype wire

//--- test/psu_cmd_properties.sv
// Purpose: port checks of the command handler
// Assumes: ce held high by the bench
// Notes: bound from the testbench file
`timescale 1ns/1ps
`default_nettype none
module psu_cmd_properties (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // byte engine
  input wire logic frm_stop,
  input wire logic rx_valid,
  input wire logic tx_next,
  input wire logic [7:0] tx_data,
  // plant side
  input wire logic [15:0] opp_limit,
  input wire logic [15:0] fan1_duty,
  input wire logic [15:0] fan2_duty,
  input wire logic [7:0] faults,
  input wire logic fault_clear
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // --------
  // properties
  // --------
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no pready");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
  property p_clear;
    fault_clear |-> $past(frm_stop) && !$past(fault_clear);
  endproperty
  a_clear: assert property (p_clear) else $error("bad clear pulse");
  property p_faults_drop;
    (($past(faults) & ~faults) != 8'h00) |-> fault_clear;
  endproperty
  a_faults_drop: assert property (p_faults_drop) else $error("fault lost");
  property p_opp;
    $changed(opp_limit) |-> $past(frm_stop);
  endproperty
  a_opp: assert property (p_opp) else $error("limit mid frame");
  property p_fan1;
    $changed(fan1_duty) |-> $past(frm_stop) && fan1_duty <= 16'h03e8;
  endproperty
  a_fan1: assert property (p_fan1) else $error("fan1 bad");
  property p_fan2;
    $changed(fan2_duty) |-> $past(frm_stop) && fan2_duty <= 16'h03e8;
  endproperty
  a_fan2: assert property (p_fan2) else $error("fan2 bad");
  property p_tx_hold;
    $changed(tx_data) |-> $past(tx_next) || $past(rx_valid);
  endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx moved");
  // main scenarios seen
  c_clear: cover property (fault_clear);
  c_fan1: cover property ($changed(fan1_duty));
  c_err: cover property (pready && pslverr);
endmodule : psu_cmd_properties
`default_nettype wire

//--- test/host_model.sv
// Purpose: host side model driving byte engine events
// Assumes: bytes include both address bytes
// Notes: pec worked out here, never taken from the design
`timescale 1ns/1ps
`default_nettype none
`include "psu_params.svh"
module host_model (
  // clock
  input wire logic pclk,
  // events to the handler
  output logic frm_start,
  output logic frm_stop,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic tx_next,
  // read data from the handler
  input wire logic [7:0] tx_data
);
  logic [7:0] crc = 8'h00;
  initial begin
    frm_start = 1'b0;
    frm_stop = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_next = 1'b0;
  end
  // crc8 step, msb first
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] b);
    logic [7:0] x;
    x = c ^ b;
    for (int i = 0; i < 8; i++)
      x = x[7] ? ({x[6:0], 1'b0} ^ 8'h07) : {x[6:0], 1'b0};
    return x;
  endfunction : crc8
  // start or stop pulse
  task automatic mark(input logic stp);
    @(posedge pclk);
    frm_start <= !stp;
    frm_stop <= stp;
    @(posedge pclk);
    frm_start <= 1'b0;
    frm_stop <= 1'b0;
  endtask : mark
  // one byte; released data line shows the inverse
  task automatic put(input logic [7:0] b);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= b;
    crc = crc8(crc, b);
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data <= ~b;
  endtask : put
  // write frame, low byte first, pec optionally corrupted
  task automatic wr(input logic [7:0] c, input int n, input logic [15:0] d,
                    input logic bad);
    crc = 8'h00;
    mark(1'b0);
    put({`SLAVE_ADDR_DEF, 1'b0});
    put(c);
    if (n > 0) begin
      put(d[7:0]);
      put(d[15:8]);
    end
    put(crc ^ {7'h00, bad});
    mark(1'b1);
  endtask : wr
  // read frame with repeated start, pec compared at the end
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] v,
                    output logic ok);
    logic [7:0] b;
    crc = 8'h00;
    v = 16'h0000;
    ok = 1'b0;
    mark(1'b0);
    put({`SLAVE_ADDR_DEF, 1'b0});
    put(c);
    mark(1'b0);
    put({`SLAVE_ADDR_DEF, 1'b1});
    for (int i = 0; i <= n; i++) begin
      @(posedge pclk);
      b = tx_data;
      if (i < n) begin
        v[8*i +: 8] = b;
        crc = crc8(crc, b);
      end else
        ok = (b === crc);
      tx_next <= 1'b1;
      @(posedge pclk);
      tx_next <= 1'b0;
    end
    mark(1'b1);
  endtask : rd
endmodule : host_model
`default_nettype wire

//--- test/testbench.sv
// Purpose: self checking bench of the command handler
// Assumes: ce held high, default slave address
// Notes: registers over apb, frames through host_model
`timescale 1ns/1ps
`default_nettype none
`include "psu_params.svh"
`define CHK(a, x, m) \
  begin \
    n_checks++; \
    if ((a) !== (x)) begin \
      num_errors++; \
      $display("MISMATCH %0t %s", $time, m); \
    end \
  end
module testbench;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, e, ok;
  logic [7:0] paddr, rx_data, tx_data, fault_set, faults;
  logic [31:0] pwdata, prdata, r;
  logic frm_start, frm_stop, rx_valid, tx_next, fault_clear;
  logic [15:0] pot_level, vout_setpoint, opp_limit, fan1_duty, fan2_duty, v;
  int num_errors = 0;
  int n_checks = 0;
  int n_clr = 0;
  always #10 pclk = ~pclk;
  // count clear pulses, one per accepted clear frame
  always @(posedge pclk) begin
    if (fault_clear === 1'b1) n_clr++;
  end
  // --------
  // design and host
  // --------
  psu_pmbus_command_handler uut (.pclk, .presetn, .ce(1'b1), .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .frm_start, .frm_stop, .rx_valid, .rx_data, .tx_next, .tx_data,
    .pot_level, .fault_set, .vout_setpoint, .opp_limit, .fan1_duty,
    .fan2_duty, .faults, .fault_clear);
  host_model u_host (.pclk, .frm_start, .frm_stop, .rx_valid, .rx_data,
    .tx_next, .tx_data);
  // --------
  // tasks
  // --------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  // apb transfer, result left in r and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      print_verdict();
    end
  endtask : apb
  task automatic rdchk(input logic [7:0] c, input int n, input logic [15:0] x);
    u_host.rd(c, n, v, ok);
    `CHK(v, x, "read value")
    `CHK(ok, 1'b1, "read pec")
  endtask : rdchk
  // write frame, then let outputs settle
  task automatic wrs(input logic [7:0] c, input int n, input logic [15:0] d,
                     input logic bad);
    u_host.wr(c, n, d, bad);
    repeat (3) @(posedge pclk);
  endtask : wrs
  task automatic fan(input logic [7:0] c, input logic [15:0] d, f1, f2);
    wrs(c, 2, d, 1'b0);
    `CHK(fan1_duty, f1, "fan1 duty")
    `CHK(fan2_duty, f2, "fan2 duty")
  endtask : fan
  // --------
  // sequence
  // --------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    pot_level = 16'h00c8;
    fault_set = 8'h00;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(opp_limit, 16'h35e8, "opp reset")
    apb(1'b0, `OFS_VREF, 32'h0);
    `CHK(r, 32'h0000_00f0, "vref reset")
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b1, `OFS_MAX_I, 32'h0000_ffff);
    apb(1'b1, `OFS_MIN_I, 32'h0000_0096);
    apb(1'b1, `OFS_FAN_DUTY, 32'h0000_03e8);
    apb(1'b1, `OFS_REMOTE, 32'h0000_0002);
    rdchk(`CMD_MAX_CURRENT, 2, 16'hffff);
    rdchk(`CMD_MIN_CURRENT, 2, 16'h0096);
    rdchk(`CMD_FAN_DUTY, 2, 16'h03e8);
    rdchk(`CMD_REMOTE_STAT, 1, 16'h0000);
    $display("test reports done");
    apb(1'b1, `OFS_CTRL, 32'h1);
    apb(1'b1, `OFS_MAX_I, 32'h0000_1234);
    rdchk(`CMD_MAX_CURRENT, 2, 16'h1234);
    rdchk(`CMD_REMOTE_STAT, 1, 16'h0001);
    wrs(`CMD_SET_VREF, 2, 16'h0108, 1'b0);
    `CHK(vout_setpoint, 16'h0108, "remote setpoint")
    wrs(`CMD_SET_VREF, 2, 16'h00d8, 1'b1);
    `CHK(vout_setpoint, 16'h0108, "bad pec applied")
    apb(1'b0, `OFS_STATUS, 32'h0);
    `CHK(r[0], 1'b1, "pec error flag")
    apb(1'b1, `OFS_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(vout_setpoint, 16'h00c8, "local setpoint")
    rdchk(`CMD_MAX_CURRENT, 2, 16'hffff);
    $display("test setpoint done");
    wrs(`CMD_OPP_LIMIT, 2, 16'h2710, 1'b0);
    `CHK(opp_limit, 16'h35e8, "limit while disabled")
    apb(1'b1, `OFS_CTRL, 32'h0000_0100);
    wrs(`CMD_OPP_LIMIT, 2, 16'h2710, 1'b0);
    `CHK(opp_limit, 16'h2710, "limit enabled")
    apb(1'b1, `OFS_FAN_DUTY, 32'h0000_0320);
    fan(`CMD_FAN1_DUTY, 16'h01f4, 16'h0000, 16'h0000);
    fan(`CMD_FAN1_DUTY, 16'h0384, 16'h0384, 16'h0000);
    fan(`CMD_FAN2_DUTY, 16'h03e8, 16'h0384, 16'h03e8);
    fan(`CMD_FAN2_DUTY, 16'h03e9, 16'h0384, 16'h03e8);
    fan(`CMD_FAN1_DUTY, 16'h0000, 16'h0000, 16'h03e8);
    $display("test settings done");
    @(posedge pclk);
    fault_set <= 8'h5a;
    @(posedge pclk);
    fault_set <= 8'h00;
    repeat (3) @(posedge pclk);
    `CHK(faults, 8'h5a, "faults latched")
    wrs(`CMD_CLEAR_FAULTS, 0, 16'h0, 1'b0);
    `CHK(faults, 8'h00, "faults cleared")
    `CHK(n_clr, 1, "one clear pulse")
    apb(1'b0, 8'h24, 32'h0);
    `CHK(e, 1'b1, "unmapped error")
    `CHK(r, 32'h0, "unmapped data")
    $display("test faults done");
    print_verdict();
  end
endmodule : testbench
bind psu_pmbus_command_handler psu_cmd_properties u_props (.pclk, .presetn,
  .psel, .penable, .pready, .pslverr, .frm_stop, .rx_valid, .tx_next,
  .tx_data, .opp_limit, .fan1_duty, .fan2_duty, .faults, .fault_clear);
`default_nettype wire
